// ---- shared/adc_port_pkg.sv ----
// Purpose: Shared constants for the converter read port and its bus master
// Assumes: 100 MHz system clock, one clock domain
// Notes:   Pin timing is modelled as clock-enable pulses
package adc_port_pkg;
   localparam int unsigned SAMPLE_WIDTH      = 8;
   localparam int unsigned ADDR_WIDTH        = 16;
   localparam int unsigned DATA_WIDTH        = 16;
   localparam int unsigned ADDR_SELECT_BIT   = 11;
   localparam logic [15:0] CONVERTER_ADDR    = 16'h0800;
   localparam logic [15:0] MEM_START_ADDR    = 16'h0F00;
   localparam logic [15:0] SAMPLE_COUNT      = 16'h001E;
   // Clock timing
   localparam int unsigned SYS_CLK_MHZ       = 100;
   localparam int unsigned CONV_CLK_MHZ      = 40;
   localparam real         CONV_MIN_HIGH_NS  = 12.5;
   localparam real         CONV_MIN_LOW_NS   = 12.5;
   localparam real         SYS_PERIOD_NS     = 1000.0 / SYS_CLK_MHZ;
   // Least times round up, never below one cycle
   localparam int unsigned CONV_HIGH_CYCLES  =
      ($ceil(CONV_MIN_HIGH_NS / SYS_PERIOD_NS) < 1.0) ? 1 :
      int'($ceil(CONV_MIN_HIGH_NS / SYS_PERIOD_NS));
   localparam int unsigned CONV_LOW_CYCLES   =
      ($ceil(CONV_MIN_LOW_NS / SYS_PERIOD_NS) < 1.0) ? 1 :
      int'($ceil(CONV_MIN_LOW_NS / SYS_PERIOD_NS));
   // Two port sync flops, its drive flop, two read sync flops, one spare
   localparam int unsigned READ_STROBE_CYCLES = 6;
   typedef enum logic [2:0] {
      CAP_IDLE    = 3'b000,
      CAP_SAVE    = 3'b001,
      CAP_STROBE  = 3'b010,
      CAP_STORE   = 3'b011,
      CAP_RESTORE = 3'b100
   } capture_state_t;
endpackage

// ---- shared/adc_bus_if.sv ----
// Purpose: Pins between converter read port and processor I/O bus master
// Assumes: Single clock, data bus resolved from enables in this interface
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none
interface adc_bus_if;
   import adc_port_pkg::*;
   logic                      processorClockOut;
   logic [ADDR_WIDTH-1:0]     address;
   logic                      ioSpaceSelectN;
   logic                      externalAccessStrobeN;
   logic                      readNotWrite;
   logic [SAMPLE_WIDTH-1:0]   portDataOut;
   logic                      portDataOe;
   logic [SAMPLE_WIDTH-1:0]   busDataIn;
   // Resolved bus: converter drives low byte only while enabled
   assign busDataIn = portDataOe ? portDataOut : '0;
   modport device (
      input  processorClockOut, address, ioSpaceSelectN,
             externalAccessStrobeN, readNotWrite,
      output portDataOut, portDataOe
   );
   modport host (
      output processorClockOut, address, ioSpaceSelectN,
             externalAccessStrobeN, readNotWrite,
      input  busDataIn
   );
endinterface
`default_nettype wire

// ---- rtl/adc_read_port.sv ----
// Purpose: Converter-side latch and three-state read port
// Assumes: Bus pins come from another domain and are synchronised here
// Notes:   Output enable is modelled by portDataOe
`timescale 1ns/1ps
`default_nettype none
module adc_read_port (
   input  wire logic                            clk_sys,
   input  wire logic                            nrst,
   adc_bus_if.device                            bus,
   input  wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] convData,
   output logic                                 sampleTaken
);
   import adc_port_pkg::*;

   logic                    clkSync1_q, clkSync2_q, clkPrev_q;
   logic [SAMPLE_WIDTH-1:0] dataSync1_q, dataSync2_q, latch_q;
   logic                    selSync1_q, selSync2_q, strobeSync1_q, strobeSync2_q;
   logic                    addrSync1_q, addrSync2_q, rdSync1_q, rdSync2_q;
   logic                    enable_q, enablePrev_q;
   logic                    readQualified;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clkSync1_q    <= 1'b0;
         clkSync2_q    <= 1'b0;
         dataSync1_q   <= '0;
         dataSync2_q   <= '0;
         selSync1_q    <= 1'b1;
         selSync2_q    <= 1'b1;
         strobeSync1_q <= 1'b1;
         strobeSync2_q <= 1'b1;
         addrSync1_q   <= 1'b0;
         addrSync2_q   <= 1'b0;
         rdSync1_q     <= 1'b0;
         rdSync2_q     <= 1'b0;
      end else begin
         clkSync1_q    <= bus.processorClockOut;
         clkSync2_q    <= clkSync1_q;
         dataSync1_q   <= convData;
         dataSync2_q   <= dataSync1_q;
         selSync1_q    <= bus.ioSpaceSelectN;
         selSync2_q    <= selSync1_q;
         strobeSync1_q <= bus.externalAccessStrobeN;
         strobeSync2_q <= strobeSync1_q;
         addrSync1_q   <= bus.address[ADDR_SELECT_BIT];
         addrSync2_q   <= addrSync1_q;
         rdSync1_q     <= bus.readNotWrite;
         rdSync2_q     <= rdSync1_q;
      end
   end

   // ----------------------------------------
   // Sample latch
   // ----------------------------------------
   // Updates on converter clock edges only, never on bus activity
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clkPrev_q <= 1'b0;
         latch_q   <= '0;
      end else begin
         clkPrev_q <= clkSync2_q;
         if (clkSync2_q && !clkPrev_q) begin
            latch_q <= dataSync2_q;
         end
      end
   end

   // ----------------------------------------
   // Read decode and bus drive
   // ----------------------------------------
   assign readQualified = addrSync2_q && !selSync2_q && !strobeSync2_q && rdSync2_q;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         enable_q     <= 1'b0;
         enablePrev_q <= 1'b0;
         sampleTaken  <= 1'b0;
      end else begin
         enable_q     <= readQualified;
         enablePrev_q <= enable_q;
         sampleTaken  <= enable_q && !enablePrev_q;
      end
   end

   // Data frozen for the whole enable window so one read sees one sample
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bus.portDataOut <= '0;
         bus.portDataOe  <= 1'b0;
      end else begin
         bus.portDataOe <= readQualified;
         if (readQualified && !enable_q) begin
            bus.portDataOut <= latch_q;
         end
      end
   end
endmodule // adc_read_port
`default_nettype wire

// ---- rtl/adc_capture_master.sv ----
//
// Overview of operation
// - Enable when address line eleven high, select low
// - Converter buffer drives bus only during reads
// - Decode also qualified by external access strobe
// - Processor supplies 40 MHz converter clock; here 25 MHz from the 100 MHz clk_sys
// - Converter byte lands on data bits 7..0
// - Converter data held in eight-bit latch
// - Core and converter clock share 40 MHz; here core runs at 100 MHz, converter clock at 25 MHz
// - Fixed sample count, one read per sample
// - Samples stored consecutively from 0F00h
// - Mask interrupts, save context on entry
// - Stop at count, restore, unmask interrupts
// - Converter clock high and low each 12.5 ns; here each is two cycles, 20 ns
//
// Purpose: Processor-side bus master running the capture routine
// Assumes: Samples written to a local memory array
// Notes:   Converter clock derived by divider from clk_sys
`timescale 1ns/1ps
`default_nettype none
module adc_capture_master #(
   parameter int unsigned MEM_DEPTH = 64
) (
   input  wire logic                                clk_sys,
   input  wire logic                                nrst,
   adc_bus_if.host                                  bus,
   input  wire logic                                startCapture,
   output logic                                     globalInterruptMask,
   output logic                                     captureBusy,
   output logic                                     captureDone,
   output logic [adc_port_pkg::ADDR_WIDTH-1:0]      lastStoreAddr,
   output logic [adc_port_pkg::SAMPLE_WIDTH-1:0]    lastSample
);
   import adc_port_pkg::*;

   localparam int unsigned DIV_WIDTH = 4;
   localparam logic [DIV_WIDTH-1:0] HIGH_CNT = DIV_WIDTH'(CONV_HIGH_CYCLES - 1);
   localparam logic [DIV_WIDTH-1:0] LOW_CNT  = DIV_WIDTH'(CONV_LOW_CYCLES - 1);
   localparam logic [DIV_WIDTH-1:0] STROBE_CNT = DIV_WIDTH'(READ_STROBE_CYCLES - 1);
   localparam int unsigned IDX_WIDTH = $clog2(MEM_DEPTH);

   capture_state_t           state_q, state_d;
   logic [DIV_WIDTH-1:0]     divCnt_q, strobeCnt_q;
   logic [ADDR_WIDTH-1:0]    remain_q, storePtr_q;
   logic [IDX_WIDTH-1:0]     memIdx;
   logic [SAMPLE_WIDTH-1:0]  mem_q [MEM_DEPTH];
   logic [SAMPLE_WIDTH-1:0]  busSync1_q, busSync2_q;

   // ----------------------------------------
   // Converter clock divider
   // ----------------------------------------
   // 100 MHz cannot give exact 40 MHz; each width rounded up to two cycles, 20 ns, instead
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bus.processorClockOut <= 1'b0;
         divCnt_q              <= '0;
      end else if (bus.processorClockOut ? (divCnt_q == HIGH_CNT)
                                         : (divCnt_q == LOW_CNT)) begin
         bus.processorClockOut <= !bus.processorClockOut;
         divCnt_q              <= '0;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Read data synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         busSync1_q <= '0;
         busSync2_q <= '0;
      end else begin
         busSync1_q <= bus.busDataIn;
         busSync2_q <= busSync1_q;
      end
   end

   // ----------------------------------------
   // Capture sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CAP_IDLE:    if (startCapture) begin
                         state_d = CAP_SAVE;
                      end
         CAP_SAVE:    state_d = CAP_STROBE;
         CAP_STROBE:  if (strobeCnt_q == STROBE_CNT) begin
                         state_d = CAP_STORE;
                      end
         CAP_STORE:   state_d = (remain_q == 16'h0001) ? CAP_RESTORE : CAP_STROBE;
         CAP_RESTORE: state_d = CAP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_q <= CAP_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Strobe held long enough for the port's synchronisers and its drive
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         strobeCnt_q <= '0;
      end else if (state_q == CAP_STROBE) begin
         strobeCnt_q <= strobeCnt_q + 1'b1;
      end else begin
         strobeCnt_q <= '0;
      end
   end

   // ----------------------------------------
   // Bus pins
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bus.address               <= '0;
         bus.ioSpaceSelectN        <= 1'b1;
         bus.externalAccessStrobeN <= 1'b1;
         bus.readNotWrite          <= 1'b0;
      end else if (state_d == CAP_STROBE) begin
         bus.address               <= CONVERTER_ADDR;
         bus.ioSpaceSelectN        <= 1'b0;
         bus.externalAccessStrobeN <= 1'b0;
         bus.readNotWrite          <= 1'b1;
      end else begin
         bus.address               <= '0;
         bus.ioSpaceSelectN        <= 1'b1;
         bus.externalAccessStrobeN <= 1'b1;
         bus.readNotWrite          <= 1'b0;
      end
   end

   // ----------------------------------------
   // Context, counters and store
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         globalInterruptMask <= 1'b0;
         remain_q            <= '0;
         storePtr_q          <= '0;
         captureBusy         <= 1'b0;
         captureDone         <= 1'b0;
         lastStoreAddr       <= '0;
         lastSample          <= '0;
      end else begin
         captureDone <= 1'b0;
         unique case (state_q)
            CAP_SAVE: begin
               globalInterruptMask <= 1'b1;
               remain_q            <= SAMPLE_COUNT;
               storePtr_q          <= MEM_START_ADDR;
               captureBusy         <= 1'b1;
            end
            CAP_STORE: begin
               lastSample    <= busSync2_q;
               lastStoreAddr <= storePtr_q;
               storePtr_q    <= storePtr_q + 1'b1;
               remain_q      <= remain_q - 1'b1;
            end
            CAP_RESTORE: begin
               globalInterruptMask <= 1'b0;
               captureBusy         <= 1'b0;
               captureDone         <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // Sample memory indexed from the start address; count stays below depth
   assign memIdx = IDX_WIDTH'(storePtr_q - MEM_START_ADDR);

   always_ff @(posedge clk_sys) begin
      if (state_q == CAP_STORE) begin
         mem_q[memIdx] <= busSync2_q;
      end
   end
endmodule // adc_capture_master
`default_nettype wire

// ---- sim/adc_bus_sva.sv ----
// Purpose: Pin checks across the converter port and capture master
// Assumes: One clock, nrst synchronous active low
// Notes:   Synchroniser latency is allowed two to four edges
`timescale 1ns/1ps
`default_nettype none
module adc_bus_sva (
   input wire logic                               clk_sys,
   input wire logic                               nrst,
   input wire logic                               processorClockOut,
   input wire logic [adc_port_pkg::ADDR_WIDTH-1:0]   address,
   input wire logic                               ioSpaceSelectN,
   input wire logic                               externalAccessStrobeN,
   input wire logic                               readNotWrite,
   input wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] portDataOut,
   input wire logic                               portDataOe
);
   import adc_port_pkg::*;
   logic qualRead;
   assign qualRead = address[ADDR_SELECT_BIT] && !ioSpaceSelectN
                     && !externalAccessStrobeN && readNotWrite;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ----
   // Buffer enable, converter clock and read strobe
   // ----
   chk_oe_on_read:
      assert property ($rose(qualRead) |-> ##[2:4] portDataOe)
      else $error("buffer not enabled by read");
   chk_oe_needs_read:
      assert property ($rose(portDataOe) |-> $past(qualRead, 2))
      else $error("buffer enabled without read");
   chk_oe_release:
      assert property ($fell(qualRead) |-> ##[2:4] !portDataOe)
      else $error("buffer left driving");
   chk_clk_high_min:
      assert property ($fell(processorClockOut) |-> $past(processorClockOut, 2))
      else $error("converter clock high too short");
   chk_clk_low_min:
      assert property ($rose(processorClockOut) |-> !$past(processorClockOut, 2))
      else $error("converter clock low too short");
   chk_read_addr_ok:
      assert property (!externalAccessStrobeN |->
                       address == CONVERTER_ADDR && readNotWrite && !ioSpaceSelectN)
      else $error("strobe without converter read");
   // Repetition count equals READ_STROBE_CYCLES
   chk_strobe_width:
      assert property ($fell(externalAccessStrobeN) |->
                       !externalAccessStrobeN [*6] ##1 externalAccessStrobeN)
      else $error("read strobe width wrong");
   chk_addr_steady:
      assert property (!externalAccessStrobeN && $past(!externalAccessStrobeN)
                       |-> $stable(address))
      else $error("address moved during read");
   chk_data_steady:
      assert property (portDataOe && $past(portDataOe) |-> $stable(portDataOut))
      else $error("read data changed while driven");
   cov_oe: cover property ($rose(portDataOe));
   cov_back_to_back: cover property ($fell(portDataOe) ##1 portDataOe);
   cov_strobe: cover property ($fell(externalAccessStrobeN));
   cov_clk: cover property ($rose(processorClockOut));
endmodule // adc_bus_sva
`default_nettype wire

// ---- sim/adc_parallel_read_port_tb_top.sv ----
// Purpose: Self-checking bench joining converter port and capture master
// Assumes: Converter byte held steady through each capture run
// Notes:   Expected store addresses come from a queue model
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_read_port_tb_top;
   import adc_port_pkg::*;
   logic                    clk_sys, nrst, startCapture, sampleTaken;
   logic                    globalInterruptMask, captureBusy, captureDone;
   logic [SAMPLE_WIDTH-1:0] convData, lastSample;
   logic [ADDR_WIDTH-1:0]   lastStoreAddr, prevAddr, expAddr;
   logic [ADDR_WIDTH-1:0]   expQ[$];
   int                      num_errors, check_count, cycles, takenCount, doneCount, t;
   adc_bus_if bus ();
   adc_read_port i_adc_read_port (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
      .convData(convData), .sampleTaken(sampleTaken));
   adc_capture_master #(.MEM_DEPTH(64)) i_adc_capture_master (.clk_sys(clk_sys),
      .nrst(nrst), .bus(bus), .startCapture(startCapture),
      .globalInterruptMask(globalInterruptMask), .captureBusy(captureBusy),
      .captureDone(captureDone), .lastStoreAddr(lastStoreAddr), .lastSample(lastSample));
   adc_bus_sva i_adc_bus_sva (.clk_sys(clk_sys), .nrst(nrst),
      .processorClockOut(bus.processorClockOut), .address(bus.address),
      .ioSpaceSelectN(bus.ioSpaceSelectN), .externalAccessStrobeN(bus.externalAccessStrobeN),
      .readNotWrite(bus.readNotWrite), .portDataOut(bus.portDataOut),
      .portDataOe(bus.portDataOe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----
   // Monitor and model
   // ----
   always @(negedge clk_sys) begin
      if (nrst === 1'b1 && lastStoreAddr !== prevAddr) begin
         expAddr = (expQ.size() > 0) ? expQ.pop_front() : 16'hFFFF;
         check(lastStoreAddr, expAddr, "store addr");
         check(16'(lastSample), 16'(convData), "sample");
         check(16'(globalInterruptMask), 16'h0001, "mask while storing");
         check(16'(captureBusy), 16'h0001, "busy while storing");
      end
      prevAddr = lastStoreAddr;
      if (sampleTaken === 1'b1) takenCount++;
      if (captureDone === 1'b1) doneCount++;
      cycles++;
      // Whole plan needs about fourteen hundred and fifty cycles
      if (cycles > 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic run_capture(input logic [7:0] value, input int abortAt);
      int n;
      @(posedge clk_sys);
      #1 convData = value;
      // Latch follows the converter clock through synchronisers
      repeat (12) @(posedge clk_sys);
      takenCount = 0;
      doneCount = 0;
      expQ.delete();
      for (n = 0; n < int'(SAMPLE_COUNT); n++) expQ.push_back(MEM_START_ADDR + 16'(n));
      #1 startCapture = 1'b1;
      @(posedge clk_sys);
      #1 startCapture = 1'b0;
      n = 0;
      while (captureDone !== 1'b1 && n < 2000 && (abortAt == 0 || n < abortAt)) begin
         @(negedge clk_sys);
         n++;
      end
      if (abortAt > 0) begin
         @(posedge clk_sys);
         #1 nrst = 1'b0;
         repeat (3) @(posedge clk_sys);
         @(negedge clk_sys);
         check(16'(bus.portDataOe), 16'h0000, "oe in reset");
         check(16'(globalInterruptMask), 16'h0000, "mask in reset");
         check(16'(captureBusy), 16'h0000, "busy in reset");
         @(posedge clk_sys);
         #1 nrst = 1'b1;
      end else begin
         @(negedge clk_sys);
         check(16'(takenCount), SAMPLE_COUNT, "reads taken");
         check(16'(expQ.size()), 16'h0000, "stores missing");
         check(16'(doneCount), 16'h0001, "done pulses");
         check(16'(globalInterruptMask), 16'h0000, "mask after run");
         check(16'(captureBusy), 16'h0000, "busy after run");
         check(16'(bus.portDataOe), 16'h0000, "oe after run");
      end
      t++;
      $display("test %0d done, value %h", t, value);
   endtask
   initial begin
      nrst = 1'b0;
      startCapture = 1'b0;
      convData = '0;
      num_errors = 0;
      check_count = 0;
      cycles = 0;
      t = 0;
      prevAddr = '0;
      void'($urandom(86));
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(16'(bus.portDataOe), 16'h0000, "oe idle");
      run_capture(8'hFF, 0);
      run_capture(8'h01, 0);
      repeat (3) run_capture(8'($urandom), 0);
      // Reset in mid-run, then a clean run
      run_capture(8'($urandom), 60);
      run_capture(8'($urandom), 0);
      finish_test();
   end
endmodule // adc_parallel_read_port_tb_top
`default_nettype wire
